// ===== asr_pkg.sv
package asr_pkg;
    // Host clock
    localparam int CLK_PERIOD_NS = 100;

    // Device timing, fastest grade
    localparam int T_AA_NS = 10;
    localparam int T_WC_NS = 10;
    localparam int T_WP_NS = 8;
    localparam int T_DW_NS = 6;
    localparam int T_WHZ_NS = 6;
    localparam int T_OHZ_NS = 5;

    // Device geometry
    localparam int MEM_ADDR_W = 19;
    localparam int MEM_DATA_W = 8;

    // Synchroniser depth on the returning data pins
    localparam int SYNC_STAGES = 2;

    // Cycle counts: least times round up, never below one cycle
    localparam int ACC_CYC_RAW = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (ACC_CYC_RAW < 1) ? 1 : ACC_CYC_RAW;
    localparam int RD_WAIT_CYC = ACC_CYC + SYNC_STAGES;
    localparam int WP_NS_NEED = (T_WP_NS > T_WHZ_NS + T_DW_NS) ? T_WP_NS : T_WHZ_NS + T_DW_NS;
    localparam int WP_CYC_RAW = (WP_NS_NEED + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC = (WP_CYC_RAW < 1) ? 1 : WP_CYC_RAW;
    localparam int OHZ_CYC_RAW = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (OHZ_CYC_RAW < 1) ? 1 : OHZ_CYC_RAW;
    localparam int WC_CYC_RAW = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC = (WC_CYC_RAW < 1) ? 1 : WC_CYC_RAW;

    // Phase timer width
    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] TMR_RESET = 4'h0;

    typedef enum {
        ASR_IDLE,
        ASR_RD_ACC,
        ASR_RD_OFF,
        ASR_WR_SETUP,
        ASR_WR_PULSE,
        ASR_WR_HOLD
    } asr_state_e;
endpackage

// ===== asr_tmr_if.sv
`timescale 1ns/1ps
interface asr_tmr_if;
    import asr_pkg::*;
    logic load;
    logic [TMR_W-1:0] value;
    logic done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface

// ===== asr_timer.sv
`timescale 1ns/1ps
module asr_timer
    import asr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control
    asr_tmr_if.tmr tmr
);
    logic [TMR_W-1:0] cnt_reg;
    logic [TMR_W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (tmr.load) begin
            cnt_next = tmr.value;
        end else if (cnt_reg != TMR_RESET) begin
            cnt_next = cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= TMR_RESET;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Reloading in the done cycle must not feed back into done
    assign tmr.done = (cnt_reg == TMR_RESET);
endmodule

// ===== asr_ctl.sv
`timescale 1ns/1ps
// Summary of operation
// - A store happens only while select and write enable are both low and ends when either rises.
// - A read keeps write enable high with select and output enable low so the memory drives data.
// - A write ended by write enable with output enable low needs a pulse of turn-off plus setup.
// - With output enable high through the write only the plain write pulse width applies.
// - Select stays low for the whole select-to-end-of-write interval of every write.
// - For a read the address is presented before or together with the fall of select.
// - The host drives no write data while the memory may still drive the bus.
module asr_ctl
    import asr_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W,
    parameter int DATA_W = MEM_DATA_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    // User response
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory pins
    output logic [ADDR_W-1:0] word_address,
    output logic mem_cs_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic [DATA_W-1:0] data_bus_o,
    input wire logic [DATA_W-1:0] data_bus_i,
    output logic data_bus_oe_n
);
    if (ADDR_W != MEM_ADDR_W || DATA_W != MEM_DATA_W) begin : g_chk_geom
        $error("asr_ctl: address and data widths must match the memory");
    end
    if (RD_WAIT_CYC > 15 || WR_PULSE_CYC > 15 || TURN_CYC > 15) begin : g_chk_tmr
        $error("asr_ctl: phase timer too narrow");
    end

    asr_tmr_if tmr_if ();

    asr_timer u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tmr     (tmr_if.tmr)
    );

    asr_state_e state_reg, state_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic cs_n_reg, cs_n_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic doe_n_reg, doe_n_next;
    logic rsp_reg, rsp_next;
    logic [DATA_W-1:0] sync1_reg, sync2_reg;

    // Returning data crosses in from the pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= data_bus_i;
            sync2_reg <= sync1_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        cs_n_next = cs_n_reg;
        we_n_next = we_n_reg;
        oe_n_next = oe_n_reg;
        doe_n_next = doe_n_reg;
        rsp_next = 1'b0;
        tmr_if.load = 1'b0;
        tmr_if.value = TMR_RESET;
        case (state_reg)
            ASR_IDLE: begin
                // Deselected between accesses; no refresh needed
                cs_n_next = 1'b1;
                we_n_next = 1'b1;
                oe_n_next = 1'b1;
                doe_n_next = 1'b1;
                if (req_valid) begin
                    addr_next = req_addr;
                    wdata_next = req_wdata;
                    cs_n_next = 1'b0;
                    if (req_write) begin
                        state_next = ASR_WR_SETUP;
                    end else begin
                        // Address and output enable together: access time dominates
                        oe_n_next = 1'b0;
                        tmr_if.load = 1'b1;
                        tmr_if.value = TMR_W'(RD_WAIT_CYC - 1);
                        state_next = ASR_RD_ACC;
                    end
                end
            end
            ASR_RD_ACC: begin
                if (tmr_if.done) begin
                    rdata_next = sync2_reg;
                    rsp_next = 1'b1;
                    cs_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    tmr_if.load = 1'b1;
                    tmr_if.value = TMR_W'(TURN_CYC - 1);
                    state_next = ASR_RD_OFF;
                end
            end
            ASR_RD_OFF: begin
                // Bus turnaround before anyone may drive it again
                if (tmr_if.done) begin
                    state_next = ASR_IDLE;
                end
            end
            ASR_WR_SETUP: begin
                // Output enable held high, so memory outputs stay off
                we_n_next = 1'b0;
                doe_n_next = 1'b0;
                tmr_if.load = 1'b1;
                tmr_if.value = TMR_W'(WR_PULSE_CYC - 1);
                state_next = ASR_WR_PULSE;
            end
            ASR_WR_PULSE: begin
                if (tmr_if.done) begin
                    we_n_next = 1'b1;
                    state_next = ASR_WR_HOLD;
                end
            end
            ASR_WR_HOLD: begin
                // Select and data held one cycle past the write edge
                cs_n_next = 1'b1;
                doe_n_next = 1'b1;
                state_next = ASR_IDLE;
            end
            default: begin
                state_next = ASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ASR_IDLE;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            cs_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            doe_n_reg <= 1'b1;
            rsp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            cs_n_reg <= cs_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            doe_n_reg <= doe_n_next;
            rsp_reg <= rsp_next;
        end
    end

    assign req_ready = (state_reg == ASR_IDLE);
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;
    assign word_address = addr_reg;
    assign mem_cs_n = cs_n_reg;
    assign mem_we_n = we_n_reg;
    assign mem_oe_n = oe_n_reg;
    assign data_bus_o = wdata_reg;
    assign data_bus_oe_n = doe_n_reg;

    // Helper: length of the current write pulse
    logic [TMR_W-1:0] we_low_reg, we_low_next;
    always_comb begin
        we_low_next = TMR_RESET;
        if (!mem_we_n) begin
            we_low_next = we_low_reg + 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            we_low_reg <= TMR_RESET;
        end else begin
            we_low_reg <= we_low_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence rd_begin_s;
        $fell(mem_oe_n) && !mem_cs_n;
    endsequence
    sequence rd_answer_s;
        ##[1:8] rsp_valid;
    endsequence

    we_needs_sel_a: assert property (!mem_we_n |-> !mem_cs_n)
        else $error("write enable low while deselected");
    read_we_high_a: assert property (!mem_oe_n |-> mem_we_n && !mem_cs_n)
        else $error("read without write enable high and select low");
    read_answer_a: assert property (rd_begin_s |-> rd_answer_s)
        else $error("read issued but no answer returned");
    pulse_width_a: assert property ($rose(mem_we_n) |-> we_low_reg >= TMR_W'(WR_PULSE_CYC))
        else $error("write pulse shorter than required");
    write_oe_off_a: assert property (!mem_we_n |-> mem_oe_n && $stable(data_bus_o))
        else $error("output enable low or data moving during write");
    sel_through_write_a: assert property ($rose(mem_we_n) |-> !mem_cs_n)
        else $error("select released before end of write");
    addr_stable_a: assert property (!mem_cs_n && $past(!mem_cs_n) |-> $stable(word_address))
        else $error("address moved while selected");
    no_contention_a: assert property (!data_bus_oe_n |-> mem_oe_n && $past(mem_oe_n))
        else $error("host drives bus while memory may drive it");
endmodule

// ===== asr_sram_model.sv
`timescale 1ns/1ps
module asr_sram_model
    import asr_pkg::*;
(
    // Memory pins
    input wire logic [MEM_ADDR_W-1:0] word_address,
    input wire logic mem_cs_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic [MEM_DATA_W-1:0] data_bus,
    // Driven side of the data pins
    output logic [MEM_DATA_W-1:0] dq_o,
    output logic dq_drv,
    // Answer at the access limit instead of at once
    input wire logic slow
);
    logic [MEM_DATA_W-1:0] mem [logic [MEM_ADDR_W-1:0]];
    logic [MEM_DATA_W-1:0] last = 8'h00;
    logic [MEM_DATA_W-1:0] word;
    logic rd_on;
    assign rd_on = !mem_cs_n && !mem_oe_n && mem_we_n;
    initial begin
        dq_o = 8'hFF;
        dq_drv = 1'b0;
    end
    // Output follows the address; released pins show a changing pattern
    always @(word_address or rd_on) begin
        if (rd_on === 1'b1) begin
            word = mem.exists(word_address) ? mem[word_address] : 8'h00;
        end else begin
            word = ~last;
        end
        last = word;
        if (slow) begin
            dq_o <= #(T_AA_NS) word;
            dq_drv <= #(T_AA_NS) (rd_on === 1'b1);
        end else begin
            dq_o <= #1 word;
            dq_drv <= #1 (rd_on === 1'b1);
        end
    end
    // Store at the end of the select and write-enable overlap
    always @(posedge mem_we_n or posedge mem_cs_n) begin
        if (mem_cs_n === 1'b0 || mem_we_n === 1'b0) begin
            mem[word_address] = data_bus;
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import asr_pkg::*;
    typedef struct packed {
        logic wr;
        logic [MEM_ADDR_W-1:0] addr;
        logic [MEM_DATA_W-1:0] data;
    } asr_row_s;
    logic clk_sys, reset_n, req_valid, req_write, slow, cs_prev;
    logic [MEM_ADDR_W-1:0] req_addr, addr_prev;
    logic [MEM_DATA_W-1:0] req_wdata, q;
    wire req_ready, rsp_valid, mem_cs_n, mem_we_n, mem_oe_n, data_bus_oe_n, dq_drv;
    wire [MEM_ADDR_W-1:0] word_address;
    wire [MEM_DATA_W-1:0] rsp_rdata, data_bus_o, dq_o, data_bus;
    int n_mismatch = 0;
    int samples_checked = 0;
    asr_row_s rows [8] = '{'{1'b1, 19'h00000, 8'hA5}, '{1'b1, 19'h7FFFF, 8'h3C},
        '{1'b1, 19'h12345, 8'h81}, '{1'b0, 19'h00000, 8'hA5}, '{1'b0, 19'h7FFFF, 8'h3C},
        '{1'b0, 19'h12345, 8'h81}, '{1'b1, 19'h00000, 8'h5A}, '{1'b0, 19'h00000, 8'h5A}};

    // Shared wire: host when enabled, otherwise the memory side
    assign data_bus = !data_bus_oe_n ? data_bus_o : dq_o;

    asr_ctl dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .word_address(word_address), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .data_bus_o(data_bus_o), .data_bus_i(data_bus),
        .data_bus_oe_n(data_bus_oe_n));
    asr_sram_model mem_u (.word_address(word_address), .mem_cs_n(mem_cs_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .data_bus(data_bus), .dq_o(dq_o),
        .dq_drv(dq_drv), .slow(slow));

    function automatic bit chk(input bit bad);
        samples_checked++;
        return bad;
    endfunction
    task automatic err(input string m);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One request, held until taken, then wait for the controller to go idle
    task automatic access(input logic wr, input logic [MEM_ADDR_W-1:0] a,
        input logic [MEM_DATA_W-1:0] d, output logic [MEM_DATA_W-1:0] r);
        bit took, got, idle;
        took = 0;
        got = 0;
        idle = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        for (int n = 0; n < 20 && !took; n++) begin
            took = (req_ready === 1'b1);
            @(posedge clk_sys);
            #5;
        end
        req_valid = 1'b0;
        if (chk(!took)) err("request not taken");
        for (int n = 0; n < 10 && !idle; n++) begin
            @(posedge clk_sys);
            #5;
            if (rsp_valid === 1'b1) begin
                got = 1;
                r = rsp_rdata;
            end
            idle = (req_ready === 1'b1);
        end
        if (chk(got == wr || !idle)) err("bad completion");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        err("timeout");
        test_done;
    end
    initial cs_prev = 1'b1;
    // Pin monitors between edges
    always @(negedge clk_sys) if (reset_n) begin
        if (chk(!mem_we_n && !mem_oe_n)) err("both enables low");
        if (chk(!data_bus_oe_n && dq_drv)) err("bus contention");
        if (chk(req_ready && !mem_cs_n)) err("selected while idle");
        if (chk(!mem_we_n && mem_cs_n)) err("write outside select");
        if (chk(!cs_prev && !mem_cs_n && word_address !== addr_prev)) err("address moved");
        cs_prev <= mem_cs_n;
        addr_prev <= word_address;
    end

    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        slow = 1'b0;
        repeat (12) @(posedge clk_sys);
        #5;
        if (chk(mem_cs_n !== 1'b1 || mem_we_n !== 1'b1 || mem_oe_n !== 1'b1)) err("reset pins");
        if (chk(data_bus_oe_n !== 1'b1 || req_ready !== 1'b1)) err("reset idle");
        reset_n = 1'b1;
        @(posedge clk_sys);
        #5;
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].addr, rows[i].data, q);
            if (!rows[i].wr && chk(q !== rows[i].data)) err("read data");
        end
        // Memory answering at the access limit
        slow = 1'b1;
        access(1'b0, rows[2].addr, 8'h00, q);
        if (chk(q !== rows[2].data)) err("slow read data");
        slow = 1'b0;
        // Reset in the middle of a write
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 19'h00AAA;
        req_wdata = 8'hC3;
        repeat (2) @(posedge clk_sys);
        #5;
        req_valid = 1'b0;
        reset_n = 1'b0;
        #5;
        if (chk(mem_we_n !== 1'b1 || mem_cs_n !== 1'b1 || data_bus_oe_n !== 1'b1)) err("abort pins");
        @(posedge clk_sys);
        #5;
        reset_n = 1'b1;
        @(posedge clk_sys);
        #5;
        access(1'b0, rows[1].addr, 8'h00, q);
        if (chk(q !== rows[1].data)) err("read after abort");
        test_done;
    end
endmodule
